// File: hdl/repeat_string_prefix_decoder.sv
// Decoder and sequencer for repeated string operations (store, load,
// port output, compare and scan) under the two repeat prefixes.
// Assumes a memory port and an I/O port with valid/ready handshakes.
//
// Overview of operation
// - F3 AA stores low accumulator byte repeatedly.
// - Wide F3 AA byte fill, 64-bit mode only.
// - F3 AB stores word or doubleword repeatedly.
// - Wide F3 AB stores quadwords, 64-bit only.
// - F3 AC loads bytes into accumulator low byte.
// - F3 AD loads words or doublewords repeatedly.
// - Wide F3 AD loads quadwords, 64-bit only.
// - F3 6F outputs doublewords to data-register port.
// - Wide F3 6F outputs default size, 64-bit only.
// - F3 A6 compares bytes while equal.
// - Wide F3 A7 compares quadwords while equal.
// - F3 AE scans bytes while equal accumulator.
// - F3 AF scans elements while equal accumulator.
// - F2 A6 compares bytes while unequal.
// - F2 A7 compares elements while unequal.
// - F2 AE scans bytes until accumulator match.
// - Wide F2 AF scans quadwords, 64-bit only.
// - Extension prefix blocks legacy high-byte registers.
`timescale 1ns/10ps
`default_nettype none
module repeat_string_prefix_decoder (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] prefix,
  input wire logic [7:0] opcode,
  input wire logic wide_operand_prefix,
  input wire logic ext_prefix_present,
  input wire logic mode_64,
  input wire logic opsize_32,
  input wire logic [3:0] byte_reg_sel,
  input wire logic [63:0] count_in,
  input wire logic [63:0] src_index_in,
  input wire logic [63:0] dst_index_in,
  input wire logic [63:0] acc_in,
  input wire logic [15:0] port_in,
  output logic busy,
  output logic done,
  output logic invalid_op,
  output logic high_byte_blocked,
  output logic mismatch_stop,
  output logic [63:0] count_out,
  output logic [63:0] src_index_out,
  output logic [63:0] dst_index_out,
  output logic [63:0] acc_out,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic mem_write,
  output logic mem_src_seg,
  output logic [63:0] mem_addr,
  output logic [63:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic rdata_valid,
  input wire logic [63:0] rdata,
  output logic io_valid,
  input wire logic io_ready,
  output logic [15:0] io_port,
  output logic [63:0] io_data,
  output logic [1:0] io_size
);
  import rep_string_pkg::*;

  // ------------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------------
  op_kind_t kind_dec;
  logic [1:0] size_dec;
  logic legal_dec;
  logic wide_ok;

  // Wide forms only exist in 64-bit mode.
  assign wide_ok = !wide_operand_prefix || mode_64;

  // Classify the opcode and pick the element width.
  always_comb begin
    kind_dec = K_NONE;
    size_dec = opsize_32 ? SZ_DWORD : SZ_WORD;
    if (wide_operand_prefix) begin
      size_dec = SZ_QWORD;
    end
    if (prefix == PFX_REPEAT_EQ) begin
      if (opcode == OP_STORE_B) begin
        kind_dec = K_STORE;
      end else if (opcode == OP_STORE_W) begin
        kind_dec = K_STORE;
      end else if (opcode == OP_LOAD_B) begin
        kind_dec = K_LOAD;
      end else if (opcode == OP_LOAD_W) begin
        kind_dec = K_LOAD;
      end else if (opcode == OP_PORT_OUT_D) begin
        kind_dec = K_PORT_OUT;
        size_dec = SZ_DWORD;
      end else if (opcode == OP_CMP_B || opcode == OP_CMP_W) begin
        kind_dec = K_CMP;
      end else if (opcode == OP_SCAN_B || opcode == OP_SCAN_W) begin
        kind_dec = K_SCAN;
      end
    end else if (prefix == PFX_REPEAT_NE) begin
      if (opcode == OP_CMP_B || opcode == OP_CMP_W) begin
        kind_dec = K_CMP;
      end else if (opcode == OP_SCAN_B || opcode == OP_SCAN_W) begin
        kind_dec = K_SCAN;
      end
    end
    // Even opcodes of each pair are the byte forms.
    if (opcode != OP_PORT_OUT_D && !opcode[0]) begin
      size_dec = SZ_BYTE;
    end
    legal_dec = (kind_dec != K_NONE) && wide_ok;
  end

  // Legacy high-byte registers are unreachable under an extension prefix.
  assign high_byte_blocked = mode_64 && ext_prefix_present &&
    (byte_reg_sel[3:2] == HIGH_BYTE_REG_LO[3:2]);

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  state_t state_q, state_d;
  op_kind_t kind_q, kind_d;
  logic [1:0] size_q, size_d;
  logic while_eq_q, while_eq_d;
  logic [63:0] cnt_q, cnt_d, si_q, si_d, di_q, di_d, acc_q, acc_d;
  logic [63:0] tmp_q, tmp_d;
  logic [15:0] port_q, port_d;
  logic done_q, done_d, inv_q, inv_d, stop_q, stop_d;
  logic [63:0] step;
  logic [63:0] mask;
  logic equal_now;

  // Element width in bytes and its data mask.
  always_comb begin
    step = COUNT_ONE << size_q;
    case (size_q)
      SZ_BYTE: mask = 64'h0000_0000_0000_00FF;
      SZ_WORD: mask = 64'h0000_0000_0000_FFFF;
      SZ_DWORD: mask = 64'h0000_0000_FFFF_FFFF;
      default: mask = 64'hFFFF_FFFF_FFFF_FFFF;
    endcase
  end

  // Compare returned element against the held source or accumulator.
  assign equal_now = ((kind_q == K_CMP ? tmp_q : acc_q) & mask) ==
    (rdata & mask);

  // Next-state logic for the whole repetition.
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    size_d = size_q;
    while_eq_d = while_eq_q;
    cnt_d = cnt_q;
    si_d = si_q;
    di_d = di_q;
    acc_d = acc_q;
    tmp_d = tmp_q;
    port_d = port_q;
    done_d = 1'b0;
    inv_d = inv_q;
    stop_d = stop_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          inv_d = !legal_dec;
          stop_d = 1'b0;
          kind_d = kind_dec;
          size_d = size_dec;
          while_eq_d = (prefix == PFX_REPEAT_EQ);
          cnt_d = count_in;
          si_d = src_index_in;
          di_d = dst_index_in;
          acc_d = acc_in;
          port_d = port_in;
          // A zero count or illegal form performs no access.
          if (!legal_dec || count_in == '0) begin
            state_d = ST_DONE;
          end else if (kind_dec == K_CMP || kind_dec == K_LOAD ||
                       kind_dec == K_PORT_OUT) begin
            state_d = ST_READ_SRC;
          end else if (kind_dec == K_SCAN) begin
            state_d = ST_READ_DST;
          end else begin
            state_d = ST_ACT;
          end
        end
      end
      ST_READ_SRC: begin
        if (rdata_valid) begin
          si_d = si_q + step;
          if (kind_q == K_LOAD) begin
            // Merge loaded element into the accumulator's low part.
            acc_d = (acc_q & ~mask) | (rdata & mask);
            cnt_d = cnt_q - COUNT_ONE;
            state_d = (cnt_q == COUNT_ONE) ? ST_DONE : ST_READ_SRC;
          end else if (kind_q == K_PORT_OUT) begin
            tmp_d = rdata & mask;
            state_d = ST_ACT;
          end else begin
            tmp_d = rdata & mask;
            state_d = ST_READ_DST;
          end
        end
      end
      ST_READ_DST: begin
        if (rdata_valid) begin
          di_d = di_q + step;
          cnt_d = cnt_q - COUNT_ONE;
          // Stop on the condition that the prefix ends on.
          if (equal_now != while_eq_q) begin
            stop_d = 1'b1;
            state_d = ST_DONE;
          end else if (cnt_q == COUNT_ONE) begin
            state_d = ST_DONE;
          end else begin
            state_d = (kind_q == K_CMP) ? ST_READ_SRC : ST_READ_DST;
          end
        end
      end
      ST_ACT: begin
        if ((kind_q == K_STORE && mem_ready) ||
            (kind_q == K_PORT_OUT && io_ready)) begin
          if (kind_q == K_STORE) begin
            di_d = di_q + step;
          end
          cnt_d = cnt_q - COUNT_ONE;
          if (cnt_q == COUNT_ONE) begin
            state_d = ST_DONE;
          end else begin
            state_d = (kind_q == K_STORE) ? ST_ACT : ST_READ_SRC;
          end
        end
      end
      default: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      kind_q <= K_NONE;
      size_q <= SZ_BYTE;
      while_eq_q <= 1'b0;
      cnt_q <= '0;
      si_q <= '0;
      di_q <= '0;
      acc_q <= '0;
      tmp_q <= '0;
      port_q <= '0;
      done_q <= 1'b0;
      inv_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      size_q <= size_d;
      while_eq_q <= while_eq_d;
      cnt_q <= cnt_d;
      si_q <= si_d;
      di_q <= di_d;
      acc_q <= acc_d;
      tmp_q <= tmp_d;
      port_q <= port_d;
      done_q <= done_d;
      inv_q <= inv_d;
      stop_q <= stop_d;
    end
  end

  // ------------------------------------------------------------------
  // Port drive
  // ------------------------------------------------------------------
  // Memory reads issue one request per read state; the store writes the
  // accumulator low part into the destination segment.
  assign mem_valid = (state_q == ST_READ_SRC || state_q == ST_READ_DST ||
    (state_q == ST_ACT && kind_q == K_STORE));
  assign mem_write = (state_q == ST_ACT);
  assign mem_src_seg = (state_q == ST_READ_SRC);
  assign mem_addr = (state_q == ST_READ_SRC) ? si_q : di_q;
  assign mem_wdata = acc_q & mask;
  assign mem_size = size_q;
  assign io_valid = (state_q == ST_ACT && kind_q == K_PORT_OUT);
  assign io_port = port_q;
  assign io_data = tmp_q;
  assign io_size = size_q;
  assign busy = (state_q != ST_IDLE);
  assign done = done_q;
  assign invalid_op = inv_q;
  assign mismatch_stop = stop_q;
  assign count_out = cnt_q;
  assign src_index_out = si_q;
  assign dst_index_out = di_q;
  assign acc_out = acc_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_start_zero;
    start && !busy && count_in == '0;
  endsequence

  a_zero_count_skip: assert property (
    @(posedge mclk) disable iff (!rstn)
    s_start_zero |=> !mem_valid && !io_valid ##1 done)
    else $error("Zero count made an access.");
  a_count_decrement: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_q == ST_ACT && kind_q == K_STORE && mem_ready)
    |=> cnt_q == $past(cnt_q) - COUNT_ONE)
    else $error("Count did not drop after a store.");
  a_store_data: assert property (
    @(posedge mclk) disable iff (!rstn)
    (mem_valid && mem_write && size_q == SZ_BYTE)
    |-> mem_wdata == {56'h0, acc_q[7:0]})
    else $error("Byte store data is not the accumulator.");
  a_wide_legacy: assert property (
    @(posedge mclk) disable iff (!rstn)
    (start && !busy && wide_operand_prefix && !mode_64)
    |=> invalid_op ##1 done)
    else $error("Wide form accepted outside 64-bit mode.");
  a_high_byte: assert property (
    @(posedge mclk) disable iff (!rstn)
    (mode_64 && ext_prefix_present && byte_reg_sel[3:2] == 2'h1)
    |-> high_byte_blocked)
    else $error("High-byte register reachable under prefix.");
  a_cmp_eq_stop: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_q == ST_READ_DST && rdata_valid && while_eq_q && !equal_now)
    |=> mismatch_stop && state_q == ST_DONE)
    else $error("Repeat-equal did not stop on a mismatch.");
  a_ne_stop: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_q == ST_READ_DST && rdata_valid && !while_eq_q && equal_now)
    |=> mismatch_stop ##1 done)
    else $error("Repeat-unequal did not stop on a match.");
  a_port_target: assert property (
    @(posedge mclk) disable iff (!rstn)
    io_valid |-> io_port == port_q && io_size == SZ_DWORD)
    else $error("Port output uses wrong port or size.");
endmodule
`default_nettype wire

// File: hdl/rep_string_pkg.sv
// Constants and types for the repeated string operation engine.
// Assumes a single core clock and a memory port with valid/ready handshakes.
package rep_string_pkg;
  localparam logic [7:0] PFX_REPEAT_EQ = 8'hF3;
  localparam logic [7:0] PFX_REPEAT_NE = 8'hF2;
  localparam logic [7:0] OP_PORT_OUT_D = 8'h6F;
  localparam logic [7:0] OP_CMP_B = 8'hA6;
  localparam logic [7:0] OP_CMP_W = 8'hA7;
  localparam logic [7:0] OP_STORE_B = 8'hAA;
  localparam logic [7:0] OP_STORE_W = 8'hAB;
  localparam logic [7:0] OP_LOAD_B = 8'hAC;
  localparam logic [7:0] OP_LOAD_W = 8'hAD;
  localparam logic [7:0] OP_SCAN_B = 8'hAE;
  localparam logic [7:0] OP_SCAN_W = 8'hAF;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_QWORD = 2'h3;
  localparam logic [63:0] COUNT_ONE = 64'h0000_0000_0000_0001;
  localparam logic [3:0] HIGH_BYTE_REG_LO = 4'h4;
  typedef enum logic [2:0] {
    K_NONE, K_STORE, K_LOAD, K_PORT_OUT, K_CMP, K_SCAN
  } op_kind_t;
  typedef enum {
    ST_IDLE, ST_READ_SRC, ST_READ_DST, ST_ACT, ST_DONE
  } state_t;
endpackage

// File: sim/repeat_string_prefix_decoder_bench.sv
// Self-checking bench for the repeated string engine, seeded with 51.
// Assumes the engine's inline assertions guard its own handshake timing.
`timescale 1ns/10ps
`default_nettype none
module repeat_string_prefix_decoder_bench;
  import rep_string_pkg::*;
  // ------------------------------------------------------------
  // Signals and engine instance
  // ------------------------------------------------------------
  localparam logic [63:0] A = 64'h0123_4567_89AB_CDEF;
  logic [15:0] prt, pe;
  logic mclk, rstn, start, wop, ext, m64, o32, busy, done, inv, hbb, mss;
  logic mvl, mrd, mwr, mseg, rvl, ivl, ird, flip;
  logic [7:0] pfx, opc;
  logic [3:0] sel;
  logic [1:0] msz, isz, wsz;
  logic [15:0] iop;
  logic [63:0] cnt_i, si_i, di_i, acc_i, rdata, cnt_o, si_o, di_o, acc_o;
  logic [63:0] maddr, mwd, iod, wa, ia, wd, hit;
  logic [31:0] rr;
  integer seed, err_total, checked, nacc, cyc;

  // Engine under test.
  repeat_string_prefix_decoder repeat_string_prefix_decoder_inst (
    .mclk(mclk), .rstn(rstn), .start(start), .prefix(pfx), .opcode(opc),
    .wide_operand_prefix(wop), .ext_prefix_present(ext), .mode_64(m64),
    .opsize_32(o32), .byte_reg_sel(sel), .count_in(cnt_i),
    .src_index_in(si_i), .dst_index_in(di_i), .acc_in(acc_i),
    .port_in(prt), .busy(busy), .done(done), .invalid_op(inv),
    .high_byte_blocked(hbb), .mismatch_stop(mss), .count_out(cnt_o),
    .src_index_out(si_o), .dst_index_out(di_o), .acc_out(acc_o),
    .mem_valid(mvl), .mem_ready(mrd), .mem_write(mwr), .mem_src_seg(mseg),
    .mem_addr(maddr), .mem_wdata(mwd), .mem_size(msz),
    .rdata_valid(rvl), .rdata(rdata), .io_valid(ivl), .io_ready(ird),
    .io_port(iop), .io_data(iod), .io_size(isz)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Memory content: every byte of a word repeats the address low byte.
  function automatic logic [63:0] pat(input logic [63:0] a);
    return {8{a[7:0]}};
  endfunction

  // Lane mask for an element size.
  function automatic logic [63:0] msk(input logic [1:0] s);
    return (s == SZ_QWORD) ? ~64'h0 : (64'h1 << (8 << s)) - 64'h1;
  endfunction

  task automatic chk(input logic [63:0] g, e);
    checked = checked + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Launch one instruction and wait for its completion pulse.
  task automatic op(input logic [7:0] p, c, input logic [2:0] f,
                    input logic [63:0] n, s, d, a);
    @(posedge mclk);
    {wop, m64, o32} <= f;
    pfx <= p;
    opc <= c;
    cnt_i <= n;
    si_i <= s;
    di_i <= d;
    acc_i <= a;
    prt <= a[15:0];
    pe = a[15:0];
    start <= 1'h1;
    nacc = 0;
    wa = d;
    ia = s;
    wd = a;
    wsz = !c[0] ? SZ_BYTE : f[2] ? SZ_QWORD : f[0] ? SZ_DWORD : SZ_WORD;
    @(posedge mclk);
    start <= 1'h0;
    // The port must have been latched at the start edge.
    prt <= ~a[15:0];
    while (done !== 1'h1) @(posedge mclk);
    #1;
  endtask

  // Final architectural state, status flags and access count.
  task automatic ck(input logic [63:0] n, s, d, a, input logic [1:0] f,
                    input logic [7:0] k);
    chk(cnt_o, n);
    chk(si_o, s);
    chk(di_o, d);
    chk(acc_o, a);
    chk({mss, inv}, f);
    chk(nacc, k);
    chk(busy, 1'h0);
    $display("test ended at %0t", $time);
  endtask

  // ------------------------------------------------------------
  // Far side and stimulus
  // ------------------------------------------------------------
  // Clock generator.
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // Random stalls; a read answer never stands two cycles running.
  always @(posedge mclk) begin
    rr = $random(seed);
    mrd <= rr[0];
    ird <= rr[1];
    rvl <= !rvl && mvl && !mwr && rr[2];
    rdata <= pat(maddr) ^
             (((flip ^ (maddr == hit)) && !mseg) ? ~64'h0 : 64'h0);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  // Check every accepted write and port transfer; count all accesses.
  always @(posedge mclk) begin
    if (mvl && mwr && mrd) begin
      chk(maddr, wa);
      chk(msz, wsz);
      chk(mwd & msk(wsz), wd & msk(wsz));
      wa <= wa + (64'h1 << wsz);
      nacc <= nacc + 1;
    end
    if (mvl && !mwr && rvl) nacc <= nacc + 1;
    if (ivl && ird) begin
      chk(iop, pe);
      chk(isz, SZ_DWORD);
      chk(iod[31:0], pat(ia) & msk(SZ_DWORD));
      ia <= ia + 64'h4;
      nacc <= nacc + 1;
    end
  end

  // Reset, directed corner cases before and after a random store run, then decoding.
  initial begin
    logic [31:0] r;
    logic [63:0] n, a, e;
    {start, wop, ext, m64, o32, mrd, ird, rvl, flip} = 9'h0;
    {pfx, opc, sel, prt} = 36'h0;
    {cnt_i, si_i, di_i, acc_i, rdata, hit} = 384'h0;
    rstn = 1'h0;
    seed = 51;
    err_total = 0;
    checked = 0;
    nacc = 0;
    cyc = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'h1;
    op(8'hF3, 8'hAA, 3'h0, 64'h2, 64'h0, 64'h300, A);
    ck(64'h0, 64'h0, 64'h302, A, 2'h0, 8'h2);
    op(8'hF3, 8'hAA, 3'h6, 64'h3, 64'h0, 64'h310, A);
    ck(64'h0, 64'h0, 64'h313, A, 2'h0, 8'h3);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      n = {62'h0, r[1:0]} + 64'h1;
      a = {$random(seed), $random(seed)};
      op(8'hF3, 8'hAB, {2'h0, r[2]}, n, 64'h0, 64'h400, a);
      e = 64'h400 + (n << (r[2] ? 2 : 1));
      ck(64'h0, 64'h0, e, a, 2'h0, n[7:0]);
    end
    op(8'hF3, 8'hAB, 3'h6, 64'h2, 64'h0, 64'h320, A);
    ck(64'h0, 64'h0, 64'h330, A, 2'h0, 8'h2);
    op(8'hF3, 8'hAC, 3'h0, 64'h3, 64'h110, 64'h0, A);
    ck(64'h0, 64'h113, 64'h0, {A[63:8], 8'h12}, 2'h0, 8'h3);
    op(8'hF3, 8'hAD, 3'h0, 64'h2, 64'h120, 64'h0, A);
    ck(64'h0, 64'h124, 64'h0, {A[63:16], 16'h2222}, 2'h0, 8'h2);
    op(8'hF3, 8'hAD, 3'h6, 64'h2, 64'h130, 64'h0, A);
    ck(64'h0, 64'h140, 64'h0, pat(64'h38), 2'h0, 8'h2);
    op(8'hF3, 8'h6F, 3'h0, 64'h3, 64'h140, 64'h0, A);
    ck(64'h0, 64'h14C, 64'h0, A, 2'h0, 8'h6);
    op(8'hF3, 8'h6F, 3'h6, 64'h2, 64'h150, 64'h0, A);
    ck(64'h0, 64'h158, 64'h0, A, 2'h0, 8'h4);
    hit = 64'h202;
    op(8'hF3, 8'hA6, 3'h0, 64'h5, 64'h100, 64'h200, A);
    ck(64'h2, 64'h103, 64'h203, A, 2'h2, 8'h6);
    hit = 64'h0;
    op(8'hF3, 8'hA7, 3'h6, 64'h3, 64'h100, 64'h200, A);
    ck(64'h0, 64'h118, 64'h218, A, 2'h0, 8'h6);
    op(8'hF3, 8'hAE, 3'h0, 64'h4, 64'h0, 64'h200, 64'h0);
    ck(64'h2, 64'h0, 64'h202, 64'h0, 2'h2, 8'h2);
    op(8'hF3, 8'hAF, 3'h1, 64'h3, 64'h0, 64'h210, 64'h10101010);
    ck(64'h1, 64'h0, 64'h218, 64'h10101010, 2'h2, 8'h2);
    flip = 1'h1;
    hit = 64'h203;
    op(8'hF2, 8'hA6, 3'h0, 64'h6, 64'h100, 64'h200, A);
    ck(64'h2, 64'h104, 64'h204, A, 2'h2, 8'h8);
    hit = 64'h204;
    op(8'hF2, 8'hA7, 3'h0, 64'h5, 64'h100, 64'h200, A);
    ck(64'h2, 64'h106, 64'h206, A, 2'h2, 8'h6);
    flip = 1'h0;
    hit = 64'h0;
    op(8'hF2, 8'hAE, 3'h0, 64'h8, 64'h0, 64'h200, 64'h3);
    ck(64'h4, 64'h0, 64'h204, 64'h3, 2'h2, 8'h4);
    op(8'hF2, 8'hAF, 3'h6, 64'h5, 64'h0, 64'h200, pat(64'h18));
    ck(64'h1, 64'h0, 64'h220, pat(64'h18), 2'h2, 8'h4);
    op(8'hF3, 8'hAA, 3'h0, 64'h0, 64'h0, 64'h300, A);
    ck(64'h0, 64'h0, 64'h300, A, 2'h0, 8'h0);
    op(8'hF3, 8'hAA, 3'h4, 64'h2, 64'h0, 64'h300, A);
    chk(inv, 1'h1);
    chk(nacc, 0);
    // A store under the repeat-unequal prefix is refused without access.
    op(8'hF2, 8'hAA, 3'h0, 64'h2, 64'h0, 64'h300, A);
    ck(64'h2, 64'h0, 64'h300, A, 2'h1, 8'h0);
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      {m64, ext, sel} <= i[5:0];
      @(negedge mclk);
      chk(hbb, m64 & ext & (sel[3:2] == 2'h1));
    end
    $display("test ended at %0t", $time);
    stop_test();
  end
endmodule
`default_nettype wire
